// ---- verilog/triple_timer_unit.sv ----
// Three timers with register port and interrupt
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
// How it works
// - Timers 0 and 1 count down 8-bit
// - Run bit one preloads and starts; zero stops
// - Reload disable halts the timer at underflow; the count still reloads
// - Select picks osc/1,4,16,64 or sub-oscillator
// - Underflow rate is input over reload plus one
// - Timer 2 run bit preloads and starts; zero stops
// - Gate bit: count only while pin high
// - Timer 2 may clock from pin, capture off
// - Each underflow sets its status bit and halt wake; interrupt only if unmasked
module triple_timer_unit
  import timer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic sub_oscillator_clock,
  input wire logic gating_pin,
  output logic irq,
  output logic wake,
  output logic capture_enable
);
  logic [7:0] t0_reload, t0_ctrl, t1_reload, t1_ctrl, t2_low, t2_high, t2_ctrl;
  logic [2:0] irq_status, irq_mask;
  logic [5:0] prescale;
  logic sub_q, pin_q;
  logic [7:0] t0_count, t1_count;
  logic [15:0] t2_count;
  logic [2:0] running, underflow;
  wire logic [2:0] tick;
  wire logic [2:0] start, stop;
  wire logic t4, t16, t64, sub_edge, pin_edge;
  wire logic [7:0] read_mux;
  wire logic [2:0] next_status;

  // Select decoding used by all three timers
  function automatic logic pick_tick(input logic [2:0] sel, input logic allow_pin,
                                     input logic p4, input logic p16, input logic p64,
                                     input logic sub, input logic pin);
    if (allow_pin && sel == SEL_PIN) pick_tick = pin;
    else if (sel[2]) pick_tick = sub;
    else if (sel[1:0] == 2'h0) pick_tick = 1'b1;
    else if (sel[1:0] == 2'h1) pick_tick = p4;
    else if (sel[1:0] == 2'h2) pick_tick = p16;
    else pick_tick = p64;
  endfunction : pick_tick

  // Shared prescaler and rising-edge detectors for slow clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale <= '0;
      sub_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      prescale <= prescale + 1'b1;
      sub_q <= sub_oscillator_clock;
      pin_q <= gating_pin;
    end
  end
  assign t4 = (prescale[1:0] == 2'h3);
  assign t16 = (prescale[3:0] == 4'hF);
  assign t64 = (prescale == 6'h3F);
  assign sub_edge = sub_oscillator_clock && !sub_q;
  assign pin_edge = gating_pin && !pin_q;

  assign tick[0] = pick_tick(t0_ctrl[SEL_MSB:SEL_LSB], 1'b0, t4, t16, t64, sub_edge, pin_edge);
  assign tick[1] = pick_tick(t1_ctrl[SEL_MSB:SEL_LSB], 1'b0, t4, t16, t64, sub_edge, pin_edge);
  assign tick[2] = pick_tick(t2_ctrl[SEL_MSB:SEL_LSB], 1'b1, t4, t16, t64, sub_edge, pin_edge);

  // Run bit writes: one starts, zero stops
  assign start[0] = wr && addr == ADDR_T0_CTRL && wdata[BIT_RUN];
  assign stop[0] = wr && addr == ADDR_T0_CTRL && !wdata[BIT_RUN];
  assign start[1] = wr && addr == ADDR_T1_CTRL && wdata[BIT_RUN];
  assign stop[1] = wr && addr == ADDR_T1_CTRL && !wdata[BIT_RUN];
  assign start[2] = wr && addr == ADDR_T2_CTRL && wdata[BIT_RUN];
  assign stop[2] = wr && addr == ADDR_T2_CTRL && !wdata[BIT_RUN];

  timer_down_counter #(.WIDTH(8)) u_t0 (
    .clk(clk), .rst(rst), .start(start[0]), .stop(stop[0]), .tick(tick[0]),
    .gate_ok(1'b1), .reload_dis(t0_ctrl[BIT_RELOAD_DIS]), .reload(t0_reload),
    .count(t0_count), .running(running[0]), .underflow(underflow[0])
  );
  timer_down_counter #(.WIDTH(8)) u_t1 (
    .clk(clk), .rst(rst), .start(start[1]), .stop(stop[1]), .tick(tick[1]),
    .gate_ok(1'b1), .reload_dis(t1_ctrl[BIT_RELOAD_DIS]), .reload(t1_reload),
    .count(t1_count), .running(running[1]), .underflow(underflow[1])
  );
  // Gate qualifies timer 2 by pin level, also when the pin is the clock
  timer_down_counter #(.WIDTH(16)) u_t2 (
    .clk(clk), .rst(rst), .start(start[2]), .stop(stop[2]), .tick(tick[2]),
    .gate_ok(!t2_ctrl[BIT_GATE] || gating_pin),
    .reload_dis(t2_ctrl[BIT_RELOAD_DIS]), .reload({t2_high, t2_low}),
    .count(t2_count), .running(running[2]), .underflow(underflow[2])
  );

  // Sticky status: set wins over write-one-to-clear
  assign next_status = (irq_status & ~((wr && addr == ADDR_IRQ_STATUS) ? wdata[2:0] : 3'h0))
                       | underflow;

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      t0_reload <= RESET_BYTE;
      t0_ctrl <= RESET_BYTE;
      t1_reload <= RESET_BYTE;
      t1_ctrl <= RESET_BYTE;
      t2_low <= RESET_BYTE;
      t2_high <= RESET_BYTE;
      t2_ctrl <= RESET_BYTE;
      irq_mask <= 3'h0;
      irq_status <= 3'h0;
    end else begin
      irq_status <= next_status;
      if (wr) begin
        if (addr == ADDR_T0_RELOAD) t0_reload <= wdata;
        else if (addr == ADDR_T0_CTRL) t0_ctrl <= wdata & CTRL_MASK_T01;
        else if (addr == ADDR_T1_RELOAD) t1_reload <= wdata;
        else if (addr == ADDR_T1_CTRL) t1_ctrl <= wdata & CTRL_MASK_T01;
        else if (addr == ADDR_T2_LOW) t2_low <= wdata;
        else if (addr == ADDR_T2_HIGH) t2_high <= wdata;
        else if (addr == ADDR_T2_CTRL) t2_ctrl <= wdata & CTRL_MASK_T2;
        else if (addr == ADDR_IRQ_MASK) irq_mask <= wdata[2:0];
      end
    end
  end

  // Read decode; run bit shows live running state
  assign read_mux =
    (addr == ADDR_T0_RELOAD) ? t0_reload :
    (addr == ADDR_T0_CTRL) ? {running[0], t0_ctrl[6:0]} :
    (addr == ADDR_T1_RELOAD) ? t1_reload :
    (addr == ADDR_T1_CTRL) ? {running[1], t1_ctrl[6:0]} :
    (addr == ADDR_T2_LOW) ? t2_low :
    (addr == ADDR_T2_HIGH) ? t2_high :
    (addr == ADDR_T2_CTRL) ? {running[2], t2_ctrl[6:0]} :
    (addr == ADDR_IRQ_STATUS) ? {5'h00, irq_status} :
    (addr == ADDR_IRQ_MASK) ? {5'h00, irq_mask} :
    (addr == ADDR_T0_COUNT) ? t0_count :
    (addr == ADDR_T1_COUNT) ? t1_count :
    (addr == ADDR_T2_COUNT_LOW) ? t2_count[7:0] :
    (addr == ADDR_T2_COUNT_HIGH) ? t2_count[15:8] : 8'h00;

  // Registered outputs; wake ignores the mask so halt always ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      irq <= 1'b0;
      wake <= 1'b0;
      capture_enable <= 1'b1;
    end else begin
      rdata <= rd ? read_mux : 8'h00;
      irq <= |(next_status & irq_mask);
      wake <= |underflow;
      capture_enable <= (t2_ctrl[SEL_MSB:SEL_LSB] != SEL_PIN);
    end
  end

  // Underflow of timer 0 from zero: reload seen in the same cycle as the flag
  sequence t0_uf_s;
    underflow[0] && !$past(start[0]) && !$past(stop[0]);
  endsequence
  property t0_reload_p;
    @(posedge clk) disable iff (rst)
      t0_uf_s |-> t0_count == $past(t0_reload);
  endproperty
  chk_t0_reload_value: assert property (t0_reload_p) else $error("t0 not reloaded");

  chk_start_preload: assert property (@(posedge clk) disable iff (rst)
    start[1] |=> running[1] && t1_count == $past(t1_reload)) else $error("t1 preload");

  chk_stop_clears: assert property (@(posedge clk) disable iff (rst)
    stop[2] |=> !running[2]) else $error("t2 not stopped");

  chk_step_down: assert property (@(posedge clk) disable iff (rst)
    running[0] && tick[0] && t0_count != 8'h00 && !start[0] && !stop[0]
    |=> t0_count == $past(t0_count) - 8'h01) else $error("t0 step");

  chk_gate_hold: assert property (@(posedge clk) disable iff (rst)
    t2_ctrl[BIT_GATE] && !gating_pin && !start[2] |=> t2_count == $past(t2_count))
    else $error("gate ignored");

  chk_oneshot_halt: assert property (@(posedge clk) disable iff (rst)
    underflow[1] && t1_ctrl[BIT_RELOAD_DIS] && !$past(start[1]) && !start[1] |-> ##0 !running[1])
    else $error("t1 kept running");

  chk_status_sticky: assert property (@(posedge clk) disable iff (rst)
    underflow[2] |=> irq_status[2] && (irq || !irq_mask[2])) else $error("status");

  chk_wake_pulse: assert property (@(posedge clk) disable iff (rst)
    |underflow |=> wake) else $error("no wake");

  chk_pin_capture: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_T2_CTRL && wdata[2:0] == SEL_PIN |=> ##1 !capture_enable)
    else $error("capture on");

  chk_t2_width: assert property (@(posedge clk) disable iff (rst)
    start[2] |=> t2_count == {$past(t2_high), $past(t2_low)}) else $error("t2 load");

  // Underflow not disturbed by a run bit write one edge earlier
  sequence t1_uf_s;
    underflow[1] && !$past(start[1]) && !$past(stop[1]);
  endsequence
  sequence t2_uf_s;
    underflow[2] && !$past(start[2]) && !$past(stop[2]);
  endsequence

  // Timer 1 reloads on underflow like timer 0
  chk_t1_reload_value: assert property (@(posedge clk) disable iff (rst)
    t1_uf_s |-> t1_count == $past(t1_reload)) else $error("t1 not reloaded");

  // Timer 2 reloads the full two-byte value
  chk_t2_reload_value: assert property (@(posedge clk) disable iff (rst)
    t2_uf_s |-> t2_count == {$past(t2_high), $past(t2_low)}) else $error("t2 not reloaded");

  // Auto-reload keeps timer 0 running across underflow
  chk_t0_autoreload: assert property (@(posedge clk) disable iff (rst)
    underflow[0] && !$past(t0_ctrl[BIT_RELOAD_DIS]) && !$past(stop[0]) |-> running[0])
    else $error("t0 halted with reload on");

  // One-shot timer 0 halts after underflow
  chk_t0_oneshot: assert property (@(posedge clk) disable iff (rst)
    underflow[0] && $past(t0_ctrl[BIT_RELOAD_DIS]) && !$past(start[0]) |-> !running[0])
    else $error("t0 kept running");

  // One-shot timer 2 halts after underflow
  chk_t2_oneshot: assert property (@(posedge clk) disable iff (rst)
    underflow[2] && $past(t2_ctrl[BIT_RELOAD_DIS]) && !$past(start[2]) |-> !running[2])
    else $error("t2 kept running");

  // Timer 1 steps once per tick
  chk_t1_step_down: assert property (@(posedge clk) disable iff (rst)
    running[1] && tick[1] && t1_count != 8'h00 && !start[1] && !stop[1]
    |=> t1_count == $past(t1_count) - 8'h01) else $error("t1 step");

  // Timer 2 steps once per qualified tick
  chk_t2_step_down: assert property (@(posedge clk) disable iff (rst)
    running[2] && tick[2] && (!t2_ctrl[BIT_GATE] || gating_pin) && t2_count != 16'h0000
    && !start[2] && !stop[2] |=> t2_count == $past(t2_count) - 16'h0001)
    else $error("t2 step");

  // Timer 0 run bit one preloads and runs
  chk_t0_preload: assert property (@(posedge clk) disable iff (rst)
    start[0] |=> running[0] && t0_count == $past(t0_reload)) else $error("t0 preload");

  // Run bit zero stops timers 0 and 1
  chk_t0_stop: assert property (@(posedge clk) disable iff (rst)
    stop[0] |=> !running[0]) else $error("t0 not stopped");
  chk_t1_stop: assert property (@(posedge clk) disable iff (rst)
    stop[1] |=> !running[1]) else $error("t1 not stopped");

  // Timer 2 run bit one enables counting
  chk_t2_start_runs: assert property (@(posedge clk) disable iff (rst)
    start[2] |=> running[2]) else $error("t2 not started");

  // A stopped timer holds its count
  chk_t1_stopped_hold: assert property (@(posedge clk) disable iff (rst)
    !running[1] && !start[1] |=> t1_count == $past(t1_count)) else $error("t1 moved");

  // Fastest select ticks every clock
  chk_t0_fast_tick: assert property (@(posedge clk) disable iff (rst)
    t0_ctrl[SEL_MSB:SEL_LSB] == 3'h0 |-> tick[0]) else $error("t0 fast tick");

  // Top select bit takes the sub-oscillator edge
  chk_t0_sub_tick: assert property (@(posedge clk) disable iff (rst)
    t0_ctrl[SEL_MSB] |-> tick[0] == sub_edge) else $error("t0 sub tick");
  chk_t1_sub_tick: assert property (@(posedge clk) disable iff (rst)
    t1_ctrl[SEL_MSB] |-> tick[1] == sub_edge) else $error("t1 sub tick");

  // Pin as clock: ticks follow pin rising edges
  chk_t2_pin_tick: assert property (@(posedge clk) disable iff (rst)
    t2_ctrl[SEL_MSB:SEL_LSB] == SEL_PIN |-> tick[2] == pin_edge) else $error("t2 pin tick");

  // Any other select keeps capture on
  chk_capture_back: assert property (@(posedge clk) disable iff (rst)
    t2_ctrl[SEL_MSB:SEL_LSB] != SEL_PIN |=> capture_enable) else $error("capture off");

  // Every underflow lands in its status bit
  chk_t0_status_set: assert property (@(posedge clk) disable iff (rst)
    underflow[0] |=> irq_status[0]) else $error("t0 status");
  chk_t1_status_set: assert property (@(posedge clk) disable iff (rst)
    underflow[1] |=> irq_status[1]) else $error("t1 status");

  // Write-one clears when no new event competes
  chk_status_clear: assert property (@(posedge clk) disable iff (rst)
    wr && addr == ADDR_IRQ_STATUS && wdata[0] && !underflow[0] |=> !irq_status[0])
    else $error("status not cleared");

  // Level interrupt follows masked status while mask is steady
  chk_irq_level: assert property (@(posedge clk) disable iff (rst)
    $stable(irq_mask) |-> irq == |(irq_status & irq_mask)) else $error("irq level");

  // No wake without an underflow
  chk_wake_quiet: assert property (@(posedge clk) disable iff (rst)
    !(|underflow) |=> !wake) else $error("spurious wake");

  // Read data are zero outside the answer cycle
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00) else $error("rdata not idle");
endmodule : triple_timer_unit

// ---- inc/timer_pkg.sv ----
// Constants for the triple timer unit
package timer_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] ADDR_T0_RELOAD = 8'hC8;
  localparam logic [7:0] ADDR_T0_CTRL = 8'hC9;
  localparam logic [7:0] ADDR_T1_RELOAD = 8'hCA;
  localparam logic [7:0] ADDR_T1_CTRL = 8'hCB;
  localparam logic [7:0] ADDR_T2_LOW = 8'hCC;
  localparam logic [7:0] ADDR_T2_HIGH = 8'hCD;
  localparam logic [7:0] ADDR_T2_CTRL = 8'hCE;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hB1;
  localparam logic [7:0] ADDR_T0_COUNT = 8'hB2;
  localparam logic [7:0] ADDR_T1_COUNT = 8'hB3;
  localparam logic [7:0] ADDR_T2_COUNT_LOW = 8'hB4;
  localparam logic [7:0] ADDR_T2_COUNT_HIGH = 8'hB5;
  // Control register fields
  localparam int BIT_RUN = 7;
  localparam int BIT_RELOAD_DIS = 6;
  localparam int BIT_GATE = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  localparam logic [7:0] CTRL_MASK_T01 = 8'hC7;
  localparam logic [7:0] CTRL_MASK_T2 = 8'hE7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Prescaler divide counts
  localparam int DIV_4 = 4;
  localparam int DIV_16 = 16;
  localparam int DIV_64 = 64;
  localparam logic [2:0] SEL_PIN = 3'h7;
  localparam int NUM_TIMERS = 3;
endpackage : timer_pkg

// ---- verilog/timer_down_counter.sv ----
// One reloadable down-counter with stop-on-underflow option
`timescale 1ns/10ps
module timer_down_counter
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic gate_ok,
  input wire logic reload_dis,
  input wire logic [WIDTH-1:0] reload,
  output logic [WIDTH-1:0] count,
  output logic running,
  output logic underflow
);
  wire logic step;
  wire logic at_zero;
  assign step = running && gate_ok && tick;
  assign at_zero = (count == '0);

  // Count state; start preloads, underflow reloads and halts if reload is disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      running <= 1'b0;
      underflow <= 1'b0;
    end else begin
      underflow <= step && at_zero;
      if (start) begin
        count <= reload;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (step) begin
        if (at_zero) begin
          count <= reload;
          running <= !reload_dis;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule : timer_down_counter

// ---- tb/triple_timer_unit_tb.sv ----
// Register-level testbench for the triple timer unit
`timescale 1ns/10ps
module triple_timer_unit_tb
  import timer_pkg::*;
;
  logic clk, rst, wr, rd, sub_oscillator_clock, gating_pin, irq, wake, capture_enable;
  logic [7:0] addr, wdata, rdata, sub_div, v1, v2;
  int error_cnt, n_compared;
  logic [7:0] regs [15] = '{ADDR_T0_RELOAD, ADDR_T0_CTRL, ADDR_T1_RELOAD, ADDR_T1_CTRL,
    ADDR_T2_LOW, ADDR_T2_HIGH, ADDR_T2_CTRL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_T0_COUNT,
    ADDR_T1_COUNT, ADDR_T2_COUNT_LOW, ADDR_T2_COUNT_HIGH, 8'hC0, 8'hCF};

  triple_timer_unit dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sub_oscillator_clock(sub_oscillator_clock), .gating_pin(gating_pin),
    .irq(irq), .wake(wake), .capture_enable(capture_enable));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Slow clock of 16 cycles, stands in for the sub-oscillator
  always @(posedge clk) begin
    sub_div <= sub_div + 8'h01;
    sub_oscillator_clock <= sub_div[3];
  end

  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Data are valid only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Bounded wait for one wake pulse; returns cycles waited
  task automatic wait_wake(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (wake !== 1'b1 && n < 3000);
    if (wake !== 1'b1) begin
      check("wake pulse", 16'h0000, 16'h0001);
      results();
    end
  endtask : wait_wake

  // Two pulses to resync after a reconfiguration, then measure one period
  task automatic period(input int exp);
    int n;
    wait_wake(n);
    wait_wake(n);
    wait_wake(n);
    check("underflow period", n[15:0], exp[15:0]);
  endtask : period

  initial begin
    {rst, addr, wdata, wr, rd, gating_pin, sub_div, sub_oscillator_clock} = '0;
    rst = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unmapped places read zero
    foreach (regs[i]) begin
      rd_reg(regs[i], v1);
      check("reset value", {8'h00, v1}, 16'h0000);
    end
    check("capture enable", {15'h0, capture_enable}, 16'h0001);
    // Every clock select of timer 0, reload 3
    wr_reg(ADDR_IRQ_MASK, 8'h05);
    wr_reg(ADDR_T0_RELOAD, 8'h03);
    for (int s = 0; s < 8; s++) begin
      wr_reg(ADDR_T0_CTRL, 8'h80 | 8'(s));
      period(4 * (s > 3 ? 16 : (1 << (2 * s))));
    end
    check("irq level", {15'h0, irq}, 16'h0001);
    // Stop freezes the count
    wr_reg(ADDR_T0_CTRL, 8'h00);
    rd_reg(ADDR_T0_COUNT, v1);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_T0_COUNT, v2);
    check("stopped count", {8'h00, v2}, {8'h00, v1});
    rd_reg(ADDR_IRQ_STATUS, v1);
    check("status", {8'h00, v1}, 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", {15'h0, irq}, 16'h0000);
    // One-shot timer 1, masked first
    wr_reg(ADDR_T1_RELOAD, 8'h02);
    wr_reg(ADDR_T1_CTRL, 8'hC0);
    repeat (10) @(posedge clk);
    #1 check("masked irq", {15'h0, irq}, 16'h0000);
    rd_reg(ADDR_T1_CTRL, v1);
    check("one-shot ctrl", {8'h00, v1}, 16'h0040);
    rd_reg(ADDR_T1_COUNT, v1);
    check("one-shot count", {8'h00, v1}, 16'h0002);
    rd_reg(ADDR_IRQ_STATUS, v1);
    check("status", {8'h00, v1}, 16'h0002);
    wr_reg(ADDR_IRQ_MASK, 8'h07);
    repeat (2) @(posedge clk);
    #1 check("unmasked irq", {15'h0, irq}, 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 8'h02);
    repeat (2) @(posedge clk);
    #1 check("irq cleared", {15'h0, irq}, 16'h0000);
    // Timer 2 preload held by a low gate, then 16-bit period
    wr_reg(ADDR_T2_LOW, 8'h34);
    wr_reg(ADDR_T2_HIGH, 8'h12);
    wr_reg(ADDR_T2_CTRL, 8'hA0);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_T2_COUNT_LOW, v1);
    rd_reg(ADDR_T2_COUNT_HIGH, v2);
    check("gated preload", {v2, v1}, 16'h1234);
    wr_reg(ADDR_T2_LOW, 8'h05);
    wr_reg(ADDR_T2_HIGH, 8'h01);
    wr_reg(ADDR_T2_CTRL, 8'hA0);
    gating_pin <= 1'b1;
    period(262);
    // Pin as clock turns capture off
    wr_reg(ADDR_T2_CTRL, 8'h87);
    repeat (2) @(posedge clk);
    #1 check("capture enable", {15'h0, capture_enable}, 16'h0000);
    wr_reg(ADDR_T2_CTRL, 8'h84);
    repeat (2) @(posedge clk);
    #1 check("capture enable", {15'h0, capture_enable}, 16'h0001);
    results();
  end
endmodule : triple_timer_unit_tb
